// *** rtl/swl_loop_stack.sv ***
// counted loop stack: one remaining-iteration count per open nesting level
// assumes push, step and flush come from the same pclk domain, at most one per cycle
`timescale 1ns/1ps
module swl_loop_stack #(
  parameter int DEPTH = swl_pkg::SWL_LOOP_DEPTH,
  parameter int W = swl_pkg::SWL_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [W-1:0] push_count,
  input wire logic step,
  input wire logic flush,
  output logic empty,
  output logic full,
  output logic again
);
  import swl_pkg::*;

  localparam int PW = $clog2(DEPTH + 1);
  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] slot [DEPTH];
  logic [PW-1:0] level;
  logic [PW-1:0] top;

  // counts from the most negative value up to zero run once
  function automatic logic [W-1:0] first_count(input logic [W-1:0] c);
    return ($signed(c) <= 0) ? ONE : c;
  endfunction : first_count

  assign top = level - 1'b1;
  assign empty = (level == '0);
  assign full = (level == PW'(DEPTH));
  // more passes left on the innermost loop
  assign again = !empty && (slot[top] > ONE);

  // push opens a level, step burns one pass or closes the level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        slot[i] <= '0;
      end
    end else if (flush) begin
      level <= '0;
    end else if (push && !full) begin
      slot[level] <= first_count(push_count);
      level <= level + 1'b1;
    end else if (step && !empty) begin
      if (again) begin
        slot[top] <= slot[top] - ONE;
      end else begin
        level <= top;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_nonpos_once;
    (push && !full && !flush && ($signed(push_count) <= 0)) |=> !again;
  endproperty
  a_nonpos_once: assert property (p_nonpos_once) else $error("non-positive count not run once");

  property p_repeat_keeps_level;
    (step && again && !push && !flush) |=> (level == $past(level));
  endproperty
  a_repeat_keeps_level: assert property (p_repeat_keeps_level) else $error("loop closed early");

endmodule : swl_loop_stack

// *** rtl/swl_ms_tick.sv ***
// millisecond tick generator for the watchdog time base
// assumes pclk runs free; tick is a one-cycle pulse every CYCLES clocks
`timescale 1ns/1ps
module swl_ms_tick #(
  parameter int CYCLES = swl_pkg::SWL_MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  import swl_pkg::*;

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] div;

  // free-running divider; tick marks its wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= '0;
      tick <= 1'b0;
    end else if (div == LAST) begin
      div <= '0;
      tick <= 1'b1;
    end else begin
      div <= div + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule : swl_ms_tick

// *** rtl/swl_scan_watchdog.sv ***
// scan cycle watchdog and loop / subroutine flow checker, apb register slave
// assumes the sequencer reports each executed control instruction as a one-cycle
// ins_valid pulse on pclk, and obeys loop_repeat / loop_done / restart_step0
// Operation
// - main program end while a subroutine is still open flags an error
// - main program end while a counted loop is open flags an error
// - operation cycle runs from step zero to main end or final end
// - cycle over the limit flags watchdog error, lights error lamp, halts
// - refresh instruction restarts the watchdog measurement mid-program
// - limit word holds milliseconds, up to 32767, initial 200
// - a newly written limit applies to the program that follows; here it applies from the next clock, in the running cycle
// - main end triggers output and input processing, refresh, restart at step zero
// - loop counts from -32768 through zero run a single pass
// - loop body repeats the given count, then continues after loop end
// - counted loops nest up to five levels
// - loop end without an open loop is an error
// - unequal numbers of loop begins and loop ends are an error
// - loop end inside the routine area after main end is an error
// - the last operation cycle time is readable in the cycle time word
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module swl_scan_watchdog #(
  parameter int MS_CYCLES = swl_pkg::SWL_MS_CYCLES,
  parameter int LOOP_DEPTH = swl_pkg::SWL_LOOP_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ins_valid,
  input wire swl_pkg::swl_op_t ins_op,
  input wire logic [swl_pkg::SWL_CNT_W-1:0] ins_count,
  output logic loop_repeat,
  output logic loop_done,
  output logic io_refresh,
  output logic restart_step0,
  output logic halt,
  output logic cpu_error_led,
  output logic prog_error,
  output logic irq
);
  import swl_pkg::*;

  swl_state_t state;
  swl_state_t next_state;
  logic [15:0] limit;
  logic [15:0] wd_count;
  logic [15:0] scan_cycle_time;
  logic [SWL_ST_W-1:0] status;
  logic [SWL_ST_W-1:0] mask;
  logic [SWL_ST_W-1:0] st_set;
  logic [SWL_ST_W-1:0] st_clr;
  logic [SWL_ST_W-1:0] next_status;
  logic [3:0] call_depth;
  logic irq_ctx;
  logic ms_tick;
  logic loop_empty;
  logic loop_full;
  logic loop_again;
  logic acc;
  logic wr_en;
  logic rd_phase;
  logic [31:0] rd_data;
  logic rd_hit;
  logic ins_ok;
  logic cyc_end;
  logic main_end;
  logic refresh_instr;
  logic resume;
  logic refresh;
  logic wd_trip;
  logic in_routine;
  logic loop_begin_ev;
  logic loop_end_ev;
  logic loop_step;

  swl_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(ms_tick)
  );

  swl_loop_stack #(.DEPTH(LOOP_DEPTH), .W(SWL_CNT_W)) u_loops (
    .pclk(pclk),
    .presetn(presetn),
    .push(loop_begin_ev),
    .push_count(ins_count),
    .step(loop_step),
    .flush(cyc_end),
    .empty(loop_empty),
    .full(loop_full),
    .again(loop_again)
  );

  // apb: one wait state, so read data and error come straight from flops
  assign rd_phase = psel && penable && !pready;
  assign acc = psel && penable && pready;
  assign wr_en = acc && pwrite;

  // read mux and decode; low address bits must be zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = (paddr[1:0] == 2'h0);
    case (paddr)
      SWL_OFF_LIMIT: rd_data = {16'h0000, limit};
      SWL_OFF_CYCLE: rd_data = {16'h0000, scan_cycle_time};
      SWL_OFF_STATUS: rd_data = {26'h000_0000, status};
      SWL_OFF_MASK: rd_data = {26'h000_0000, mask};
      SWL_OFF_CTRL: rd_data = {31'h0000_0000, state == SWL_HALT};
      default: rd_hit = 1'b0;
    endcase
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_phase;
      prdata <= (rd_phase && !pwrite && rd_hit) ? rd_data : 32'h0000_0000;
      pslverr <= rd_phase && !rd_hit;
    end
  end

  // limit word and interrupt mask; bit 15 of the limit is held at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit <= SWL_LIMIT_RST;
      mask <= SWL_ST_RST;
    end else if (wr_en && paddr == SWL_OFF_LIMIT) begin
      limit <= pwdata[15:0] & SWL_LIMIT_MAX;
    end else if (wr_en && paddr == SWL_OFF_MASK) begin
      mask <= pwdata[SWL_ST_W-1:0];
    end
  end

  // instruction events; nothing executes while halted
  assign ins_ok = ins_valid && (state == SWL_RUN);
  assign cyc_end = ins_ok && swl_is_cycle_end(ins_op);
  assign main_end = ins_ok && (ins_op == SWL_OP_MAIN_PROGRAM_END);
  assign refresh_instr = ins_ok && (ins_op == SWL_OP_WATCHDOG_REFRESH);
  assign resume = wr_en && (paddr == SWL_OFF_CTRL) && pwdata[SWL_CTRL_RESUME];
  assign refresh = cyc_end || refresh_instr || resume;
  assign wd_trip = (state == SWL_RUN) && (wd_count > limit);
  assign in_routine = (call_depth != 4'h0) || irq_ctx;
  assign loop_begin_ev = ins_ok && (ins_op == SWL_OP_LOOP_BEGIN);
  assign loop_end_ev = ins_ok && (ins_op == SWL_OP_LOOP_END);
  // loop ends in the routine area are refused, not stepped
  assign loop_step = loop_end_ev && !in_routine;

  // watchdog count in ms; a refresh beats a coincident tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_count <= 16'h0000;
    end else if (refresh) begin
      wd_count <= 16'h0000;
    end else if (ms_tick && state == SWL_RUN && wd_count != SWL_COUNT_MAX) begin
      wd_count <= wd_count + 16'h0001;
    end
  end

  // cycle time is captured at each end instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cycle_time <= 16'h0000;
    end else if (cyc_end) begin
      scan_cycle_time <= wd_count;
    end
  end

  // run / halt; only software can resume after a trip
  always_comb begin
    next_state = state;
    case (state)
      SWL_RUN: if (wd_trip) next_state = SWL_HALT;
      SWL_HALT: if (resume) next_state = SWL_RUN;
      default: next_state = SWL_HALT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SWL_RUN;
      halt <= 1'b0;
      cpu_error_led <= 1'b0;
    end else begin
      state <= next_state;
      halt <= (next_state == SWL_HALT);
      cpu_error_led <= (next_state == SWL_HALT);
    end
  end

  // subroutine / interrupt nesting; resynchronised at every cycle end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_depth <= 4'h0;
      irq_ctx <= 1'b0;
    end else if (cyc_end) begin
      call_depth <= 4'h0;
      irq_ctx <= 1'b0;
    end else if (ins_ok) begin
      case (ins_op)
        SWL_OP_SUBROUTINE_CALL, SWL_OP_SUBROUTINE_CALL_PULSE: begin
          if (call_depth != SWL_DEPTH_CALL_MAX) call_depth <= call_depth + 4'h1;
        end
        SWL_OP_SUBROUTINE_RETURN: begin
          if (call_depth != 4'h0) call_depth <= call_depth - 4'h1;
        end
        SWL_OP_INTERRUPT_ENTRY: irq_ctx <= 1'b1;
        SWL_OP_INTERRUPT_RETURN: irq_ctx <= 1'b0;
        default: irq_ctx <= irq_ctx;
      endcase
    end
  end

  // error events into sticky status bits
  always_comb begin
    st_set = SWL_ST_RST;
    st_set[SWL_ST_WDT] = wd_trip;
    st_set[SWL_ST_SUB_OPEN] = main_end && (call_depth != 4'h0);
    st_set[SWL_ST_LOOP_OPEN] = cyc_end && !loop_empty;
    st_set[SWL_ST_ORDER] = loop_step && loop_empty;
    st_set[SWL_ST_REGION] = loop_end_ev && in_routine;
    st_set[SWL_ST_NEST] = loop_begin_ev && loop_full;
    st_clr = (wr_en && paddr == SWL_OFF_STATUS) ? pwdata[SWL_ST_W-1:0] : SWL_ST_RST;
    // a new event wins over a write-one-to-clear in the same cycle
    next_status = (status & ~st_clr) | st_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= SWL_ST_RST;
      prog_error <= 1'b0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      prog_error <= |st_set[SWL_ST_W-1:1];
      irq <= |(next_status & mask);
    end
  end

  // sequencer answers, one cycle after the instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_repeat <= 1'b0;
      loop_done <= 1'b0;
      io_refresh <= 1'b0;
      restart_step0 <= 1'b0;
    end else begin
      loop_repeat <= loop_step && loop_again;
      loop_done <= loop_step && !loop_empty && !loop_again;
      io_refresh <= cyc_end;
      restart_step0 <= cyc_end;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cycle_end;
    cyc_end && !wd_trip;
  endsequence
  sequence s_io_pulse;
    io_refresh && restart_step0 && (wd_count == 16'h0000) ##1 !io_refresh;
  endsequence

  property p_cycle_io;
    s_cycle_end |=> s_io_pulse;
  endproperty
  a_cycle_io: assert property (p_cycle_io) else $error("end did not refresh and restart");

  property p_wdt_trip;
    (state == SWL_RUN && wd_count > limit) |=> halt && cpu_error_led && status[SWL_ST_WDT];
  endproperty
  a_wdt_trip: assert property (p_wdt_trip) else $error("watchdog overrun not halted");

  property p_refresh_clear;
    refresh |=> (wd_count == 16'h0000);
  endproperty
  a_refresh_clear: assert property (p_refresh_clear) else $error("refresh did not clear count");

  property p_instr_refresh;
    (refresh_instr && !wd_trip) |=> (state == SWL_RUN) && (wd_count == 16'h0000) && !halt;
  endproperty
  a_instr_refresh: assert property (p_instr_refresh) else $error("refresh instruction ignored");

  property p_cycle_time;
    cyc_end |=> (scan_cycle_time == $past(wd_count));
  endproperty
  a_cycle_time: assert property (p_cycle_time) else $error("cycle time not captured");

  property p_limit_write;
    (wr_en && paddr == SWL_OFF_LIMIT) |=> (limit == ($past(pwdata[15:0]) & SWL_LIMIT_MAX));
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit write lost");

  property p_sub_open;
    (main_end && call_depth != 4'h0) |=> status[SWL_ST_SUB_OPEN] && prog_error;
  endproperty
  a_sub_open: assert property (p_sub_open) else $error("open subroutine at end not flagged");

  property p_loop_open;
    (cyc_end && !loop_empty) |=> status[SWL_ST_LOOP_OPEN] && loop_empty;
  endproperty
  a_loop_open: assert property (p_loop_open) else $error("open loop at end not flagged");

  property p_order;
    (loop_step && loop_empty) |=> status[SWL_ST_ORDER] && !loop_done && !loop_repeat;
  endproperty
  a_order: assert property (p_order) else $error("stray loop end not flagged");

  property p_region;
    (loop_end_ev && in_routine) |=> status[SWL_ST_REGION] && !loop_repeat;
  endproperty
  a_region: assert property (p_region) else $error("loop end in routine area not flagged");

  property p_nest;
    (loop_begin_ev && loop_full) |=> status[SWL_ST_NEST];
  endproperty
  a_nest: assert property (p_nest) else $error("nesting overflow not flagged");

endmodule : swl_scan_watchdog

// *** shared/swl_pkg.sv ***
// shared constants, types and helpers for the scan watchdog and loop control block
// assumes a single 25 MHz pclk domain and an APB register bus with 32-bit data
package swl_pkg;

  // time base
  localparam int SWL_CLK_HZ = 25_000_000;
  localparam int SWL_TIME_BASE_MS = 1;
  localparam int SWL_MS_CYCLES = SWL_CLK_HZ / 1000 * SWL_TIME_BASE_MS;

  // watchdog limit word, in ms
  localparam logic [15:0] SWL_LIMIT_RST = 16'h00C8;
  localparam logic [15:0] SWL_LIMIT_MAX = 16'h7FFF;
  localparam logic [15:0] SWL_COUNT_MAX = 16'hFFFF;

  // apb byte offsets
  localparam logic [7:0] SWL_OFF_LIMIT = 8'h00;
  localparam logic [7:0] SWL_OFF_CYCLE = 8'h04;
  localparam logic [7:0] SWL_OFF_STATUS = 8'h08;
  localparam logic [7:0] SWL_OFF_MASK = 8'h0C;
  localparam logic [7:0] SWL_OFF_CTRL = 8'h10;

  // status and mask bit positions
  localparam int SWL_ST_WDT = 0;
  localparam int SWL_ST_SUB_OPEN = 1;
  localparam int SWL_ST_LOOP_OPEN = 2;
  localparam int SWL_ST_ORDER = 3;
  localparam int SWL_ST_REGION = 4;
  localparam int SWL_ST_NEST = 5;
  localparam int SWL_ST_W = 6;
  localparam logic [SWL_ST_W-1:0] SWL_ST_RST = 6'h00;

  // control bit: write one to resume after a watchdog halt
  localparam int SWL_CTRL_RESUME = 0;

  // loop stack
  localparam int SWL_LOOP_DEPTH = 5;
  localparam int SWL_CNT_W = 16;
  localparam logic [3:0] SWL_DEPTH_CALL_MAX = 4'hF;

  // instruction codes reported by the sequencer
  typedef enum logic [3:0] {
    SWL_OP_NONE = 4'h0,
    SWL_OP_MAIN_PROGRAM_END = 4'h1,
    SWL_OP_FINAL_END = 4'h2,
    SWL_OP_WATCHDOG_REFRESH = 4'h3,
    SWL_OP_SUBROUTINE_CALL = 4'h4,
    SWL_OP_SUBROUTINE_CALL_PULSE = 4'h5,
    SWL_OP_SUBROUTINE_RETURN = 4'h6,
    SWL_OP_INTERRUPT_ENTRY = 4'h7,
    SWL_OP_INTERRUPT_RETURN = 4'h8,
    SWL_OP_LOOP_BEGIN = 4'h9,
    SWL_OP_LOOP_END = 4'hA
  } swl_op_t;

  typedef enum logic {
    SWL_RUN = 1'b0,
    SWL_HALT = 1'b1
  } swl_state_t;

  // both end instructions close the operation cycle
  function automatic logic swl_is_cycle_end(input swl_op_t op);
    return (op == SWL_OP_MAIN_PROGRAM_END) || (op == SWL_OP_FINAL_END);
  endfunction : swl_is_cycle_end

endpackage : swl_pkg

// *** test/tb.sv ***
// self-checking bench for the scan watchdog and loop control block
// assumes the block alone: the bench is both apb master and instruction sequencer
`timescale 1ns/1ps
module tb;
  import swl_pkg::*;
  // short millisecond so watchdog scenarios stay brief
  localparam int MS = 4;
  localparam logic [3:0] EV_REP = 4'b1000;
  localparam logic [3:0] EV_DONE = 4'b0100;
  localparam logic [3:0] EV_END = 4'b0011;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ins_valid = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdata, seed = 32'h0000_BB72;
  logic pready, pslverr, loop_repeat, loop_done, io_refresh, restart_step0, halt, cpu_error_led, prog_error, irq;
  swl_op_t ins_op = SWL_OP_NONE;
  logic [15:0] ins_count = 16'h0000;
  logic [32:0] rdq[$];
  logic [3:0] evq[$];
  logic [15:0] cnt[5] = '{16'h0002, 16'h0000, 16'h8000, 16'hFFFF, 16'h0000};
  int n_fail = 0;
  int tests_run = 0;
  int n_perr = 0;
  int i, p;

  swl_scan_watchdog #(.MS_CYCLES(MS), .LOOP_DEPTH(SWL_LOOP_DEPTH)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ins_valid(ins_valid), .ins_op(ins_op), .ins_count(ins_count), .loop_repeat(loop_repeat),
    .loop_done(loop_done), .io_refresh(io_refresh), .restart_step0(restart_step0), .halt(halt),
    .cpu_error_led(cpu_error_led), .prog_error(prog_error), .irq(irq));

  initial begin
    forever #20 pclk = ~pclk;
  end

  task automatic check(input string name, input logic [32:0] exp, input logic [32:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      check("apb wait", 33'h0, 33'h1);
      print_verdict();
    end
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    rdq.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // one executed instruction, a single-cycle valid pulse
  task automatic op(input swl_op_t o, input logic [15:0] c = 16'h0000);
    @(posedge pclk);
    ins_valid <= 1'b1;
    ins_op <= o;
    ins_count <= c;
    @(posedge pclk);
    ins_valid <= 1'b0;
  endtask : op

  task automatic settle_check(input string name, input logic e, input logic got_sel);
    repeat (2) @(negedge pclk);
    check(name, {32'h0, e}, {32'h0, got_sel ? halt : irq});
  endtask : settle_check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // read results: oldest note against the data of the completing read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rdq.size() > 0)
      check("read", rdq.pop_front(), {pslverr, prdata});
  end

  // sequencer answers: every pulse must have been announced by the driver
  always @(posedge pclk) begin
    if ({loop_repeat, loop_done, io_refresh, restart_step0} !== 4'b0000) begin
      if (evq.size() == 0)
        check("stray event", 33'h0, {29'h0, loop_repeat, loop_done, io_refresh, restart_step0});
      else
        check("event", {29'h0, evq.pop_front()}, {29'h0, loop_repeat, loop_done, io_refresh, restart_step0});
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(SWL_OFF_LIMIT, 32'h0000_00C8);
    rd(SWL_OFF_STATUS, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000, 1'b1);
    rd(8'h02, 32'h0000_0000, 1'b1);
    wr(SWL_OFF_LIMIT, 32'h0000_FFFF);
    rd(SWL_OFF_LIMIT, 32'h0000_7FFF);
    // counts at and below zero run once; last entry is random
    cnt[4] = 16'(xs() & 32'h7) + 16'h0001;
    for (i = 0; i < 5; i++) begin
      p = ($signed(cnt[i]) <= 0) ? 1 : int'($signed(cnt[i]));
      op(SWL_OP_LOOP_BEGIN, cnt[i]);
      repeat (p - 1) begin
        evq.push_back(EV_REP);
        op(SWL_OP_LOOP_END);
      end
      evq.push_back(EV_DONE);
      op(SWL_OP_LOOP_END);
    end
    // sixth level is refused, five ends close the five accepted levels
    repeat (6) op(SWL_OP_LOOP_BEGIN, 16'h0001);
    repeat (5) begin
      evq.push_back(EV_DONE);
      op(SWL_OP_LOOP_END);
    end
    rd(SWL_OFF_STATUS, 32'(1 << SWL_ST_NEST));
    wr(SWL_OFF_STATUS, 32'h0000_003F);
    op(SWL_OP_LOOP_END);
    settle_check("irq masked", 1'b0, 1'b0);
    wr(SWL_OFF_MASK, 32'(1 << SWL_ST_ORDER));
    rd(SWL_OFF_MASK, 32'(1 << SWL_ST_ORDER));
    settle_check("irq", 1'b1, 1'b0);
    rd(SWL_OFF_STATUS, 32'(1 << SWL_ST_ORDER));
    wr(SWL_OFF_STATUS, 32'(1 << SWL_ST_ORDER));
    settle_check("irq clear", 1'b0, 1'b0);
    op(SWL_OP_LOOP_BEGIN, 16'h0002);
    evq.push_back(EV_END);
    op(SWL_OP_MAIN_PROGRAM_END);
    rd(SWL_OFF_STATUS, 32'(1 << SWL_ST_LOOP_OPEN));
    wr(SWL_OFF_STATUS, 32'h0000_003F);
    op(SWL_OP_SUBROUTINE_CALL);
    op(SWL_OP_SUBROUTINE_RETURN);
    op(SWL_OP_SUBROUTINE_CALL_PULSE);
    evq.push_back(EV_END);
    op(SWL_OP_MAIN_PROGRAM_END);
    rd(SWL_OFF_STATUS, 32'(1 << SWL_ST_SUB_OPEN));
    wr(SWL_OFF_STATUS, 32'h0000_003F);
    // loop end inside a routine after main end is refused, loop stays open
    op(SWL_OP_LOOP_BEGIN, 16'h0001);
    op(SWL_OP_INTERRUPT_ENTRY);
    op(SWL_OP_LOOP_END);
    op(SWL_OP_INTERRUPT_RETURN);
    evq.push_back(EV_DONE);
    op(SWL_OP_LOOP_END);
    rd(SWL_OFF_STATUS, 32'(1 << SWL_ST_REGION));
    wr(SWL_OFF_STATUS, 32'h0000_003F);
    // cycle time over about 42 clocks is ten or eleven ticks
    wr(SWL_OFF_LIMIT, 32'd100);
    evq.push_back(EV_END);
    op(SWL_OP_FINAL_END);
    repeat (40) @(posedge pclk);
    evq.push_back(EV_END);
    op(SWL_OP_MAIN_PROGRAM_END);
    apb(1'b0, SWL_OFF_CYCLE, 32'h0000_0000);
    check("cycle time", 33'h1, {32'h0, rdata >= 32'd10 && rdata <= 32'd11});
    // limit of three leaves margin for the ticks that pass during the write itself
    wr(SWL_OFF_LIMIT, 32'd3);
    evq.push_back(EV_END);
    op(SWL_OP_MAIN_PROGRAM_END);
    repeat (10) begin
      repeat (2) @(posedge pclk);
      op(SWL_OP_WATCHDOG_REFRESH);
    end
    settle_check("halt refreshed", 1'b0, 1'b1);
    for (i = 0; i < 100 && halt !== 1'b1; i++) @(posedge pclk);
    settle_check("halt", 1'b1, 1'b1);
    check("error lamp", 33'h1, {32'h0, cpu_error_led});
    rd(SWL_OFF_STATUS, 32'(1 << SWL_ST_WDT));
    rd(SWL_OFF_CTRL, 32'h0000_0001);
    op(SWL_OP_LOOP_END);
    rd(SWL_OFF_STATUS, 32'(1 << SWL_ST_WDT));
    wr(SWL_OFF_LIMIT, 32'h0000_7FFF);
    wr(SWL_OFF_CTRL, 32'h0000_0001);
    settle_check("resume", 1'b0, 1'b1);
    wr(SWL_OFF_STATUS, 32'h0000_003F);
    rd(SWL_OFF_STATUS, 32'h0000_0000);
    repeat (5) @(posedge pclk);
    check("pending notes", 33'h0, 33'(rdq.size() + evq.size()));
    check("flow error pulses", 33'd5, 33'(n_perr));
    print_verdict();
  end

  // flow error pulses, one per refused or unbalanced instruction
  always @(posedge pclk) begin
    if (prog_error === 1'b1) n_perr++;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    check("run length", 33'h0, 33'h1);
    print_verdict();
  end
endmodule : tb
